/* design/siot_pkg.sv */
// Package with constants and types of the safe I/O test pulse unit.
package siot_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_OUT_DATA = 8'h10;
   localparam logic [7:0] ADDR_INPUTS = 8'h14;
   localparam logic [7:0] ADDR_XC_ENABLE = 8'h18;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int CTRL_LINES_OUT_BIT = 0;
   localparam int CTRL_CLOCK_MODE_BIT = 1;
   localparam int CTRL_SIG_A_BIT = 2;
   localparam int CTRL_SIG_B_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [11:0] XC_ENABLE_RESET = 12'h000;
   localparam int IRQ_CFG_ERR_BIT = 0;
   localparam int IRQ_XC_ERR_BIT = 1;
   localparam int IRQ_INPUT_CHG_BIT = 2;

   // ****************************************************************
   // Timing in cycles of the 50 MHz clock
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int TEST_CLOCK_PERIOD_US = 4;
   localparam int TEST_CLOCK_PERIOD_CYC = TEST_CLOCK_PERIOD_US * 1000 / CLK_PERIOD_NS;
   localparam int PULSE_INTERVAL_US = 40;
   localparam int PULSE_INTERVAL_CYC = PULSE_INTERVAL_US * 1000 / CLK_PERIOD_NS;
   localparam int PULSE_WIDTH_NS = 400;
   localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_NS = 200;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************************************
   // Phases of the test clock sequencer
   // ****************************************************************
   typedef enum logic [3:0] {
      SIOT_PH_A_LOW = 4'b0001,
      SIOT_PH_BOTH_HIGH_1 = 4'b0010,
      SIOT_PH_B_LOW = 4'b0100,
      SIOT_PH_BOTH_HIGH_2 = 4'b1000
   } siot_phase_t;

endpackage : siot_pkg

/* design/siot_unit.sv */
// Safe I/O unit: inputs, configurable lines, test clocks and cross-circuit check.
//
// Operation
// - Eight safe inputs plus four configurable lines
// - Configurable lines share one direction bit
// - Both clock outputs share one mode bit
// - Clock mode with output lines flags error
// - Test clocks are phase shifted
// - Even inputs check clock A, odd B
// - Safe outputs carry test pulses
// - Output states come from master logic
// - Same-clock shorts are never flagged
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module siot_unit #(
   parameter int NUM_DEDICATED = 8,
   parameter int NUM_CONFIG = 4
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Safe terminals.
   input wire logic [NUM_DEDICATED-1:0] dedicated_safe_inputs,
   input wire logic [NUM_CONFIG-1:0] configurable_safe_lines_in,
   output logic [NUM_CONFIG-1:0] configurable_safe_lines_out,
   output logic [NUM_CONFIG-1:0] configurable_safe_lines_oe,
   output logic test_clock_a_out,
   output logic test_clock_b_out,
   // Safety logic result from the master module.
   input wire logic [NUM_CONFIG-1:0] master_out_states,
   // Interrupt.
   output logic irq
);

   localparam int NIN = NUM_DEDICATED + NUM_CONFIG;

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [3:0] ctrl;
   logic [NIN-1:0] xc_enable;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [NIN-1:0] xc_err;
   logic [NIN-1:0] in_state;
   logic [NIN-1:0] in_prev;
   logic cfg_err;

   wire lines_out = ctrl[siot_pkg::CTRL_LINES_OUT_BIT];
   wire clock_mode = ctrl[siot_pkg::CTRL_CLOCK_MODE_BIT];
   wire next_cfg_err = clock_mode & lines_out;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   wire wr = psel & penable & pwrite;
   wire rd_phase = psel & ~pwrite;
   wire hit_ctrl = paddr == siot_pkg::ADDR_CTRL;
   wire hit_status = paddr == siot_pkg::ADDR_STATUS;
   wire hit_istat = paddr == siot_pkg::ADDR_IRQ_STAT;
   wire hit_imask = paddr == siot_pkg::ADDR_IRQ_MASK;
   wire hit_out = paddr == siot_pkg::ADDR_OUT_DATA;
   wire hit_in = paddr == siot_pkg::ADDR_INPUTS;
   wire hit_xce = paddr == siot_pkg::ADDR_XC_ENABLE;
   wire mapped = hit_ctrl | hit_status | hit_istat | hit_imask | hit_out | hit_in | hit_xce;
   logic [31:0] rd_mux;

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[3:0] = ctrl;
      end
      if (hit_status) begin
         rd_mux[0] = cfg_err;
         rd_mux[16 +: NIN] = xc_err;
      end
      if (hit_istat) begin
         rd_mux[2:0] = irq_stat;
      end
      if (hit_imask) begin
         rd_mux[2:0] = irq_mask;
      end
      if (hit_out) begin
         rd_mux[NUM_CONFIG-1:0] = master_out_states;
      end
      if (hit_in) begin
         rd_mux[NIN-1:0] = in_state;
      end
      if (hit_xce) begin
         rd_mux[NIN-1:0] = xc_enable;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (rd_phase & ~penable) begin
         prdata <= rd_mux;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= siot_pkg::CTRL_RESET;
         xc_enable <= siot_pkg::XC_ENABLE_RESET;
         irq_mask <= 3'h0;
      end else if (wr) begin
         if (hit_ctrl) begin
            ctrl <= pwdata[3:0];
         end
         if (hit_xce) begin
            xc_enable <= pwdata[NIN-1:0];
         end
         if (hit_imask) begin
            irq_mask <= pwdata[2:0];
         end
      end
   end

   // ****************************************************************
   // Test clock sequencer
   // ****************************************************************
   // Each clock goes low in its own quarter so a short between A and B,
   // or to the supply, shows on an input as a wrong level.
   localparam int QUARTER = siot_pkg::TEST_CLOCK_PERIOD_CYC / 4;
   siot_pkg::siot_phase_t phase;
   siot_pkg::siot_phase_t next_phase;
   logic [15:0] ph_cnt;
   wire ph_end = ph_cnt == 16'(QUARTER - 1);
   wire sample_pt = ph_cnt == 16'(siot_pkg::SETTLE_CYC);

   always_comb begin
      unique case (phase)
         siot_pkg::SIOT_PH_A_LOW: next_phase = siot_pkg::SIOT_PH_BOTH_HIGH_1;
         siot_pkg::SIOT_PH_BOTH_HIGH_1: next_phase = siot_pkg::SIOT_PH_B_LOW;
         siot_pkg::SIOT_PH_B_LOW: next_phase = siot_pkg::SIOT_PH_BOTH_HIGH_2;
         siot_pkg::SIOT_PH_BOTH_HIGH_2: next_phase = siot_pkg::SIOT_PH_A_LOW;
         default: next_phase = siot_pkg::SIOT_PH_A_LOW;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= siot_pkg::SIOT_PH_BOTH_HIGH_2;
         ph_cnt <= 16'h0000;
      end else if (ph_end) begin
         phase <= next_phase;
         ph_cnt <= 16'h0000;
      end else begin
         ph_cnt <= ph_cnt + 16'h0001;
      end
   end

   wire clk_a = phase != siot_pkg::SIOT_PH_A_LOW;
   wire clk_b = phase != siot_pkg::SIOT_PH_B_LOW;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         test_clock_a_out <= 1'b0;
         test_clock_b_out <= 1'b0;
      end else if (clock_mode) begin
         test_clock_a_out <= clk_a;
         test_clock_b_out <= clk_b;
      end else begin
         test_clock_a_out <= ctrl[siot_pkg::CTRL_SIG_A_BIT];
         test_clock_b_out <= ctrl[siot_pkg::CTRL_SIG_B_BIT];
      end
   end

   // ****************************************************************
   // Safe outputs with test pulses
   // ****************************************************************
   logic [15:0] pulse_cnt;
   wire pulse_gap = pulse_cnt < 16'(siot_pkg::PULSE_WIDTH_CYC);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt <= 16'h0000;
      end else if (pulse_cnt == 16'(siot_pkg::PULSE_INTERVAL_CYC - 1)) begin
         pulse_cnt <= 16'h0000;
      end else begin
         pulse_cnt <= pulse_cnt + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         configurable_safe_lines_out <= '0;
         configurable_safe_lines_oe <= '0;
      end else begin
         // Outputs stay off while the configuration is illegal.
         configurable_safe_lines_oe <= {NUM_CONFIG{lines_out & ~next_cfg_err}};
         configurable_safe_lines_out <= (lines_out & ~next_cfg_err & ~pulse_gap) ?
            master_out_states : '0;
      end
   end

   // ****************************************************************
   // Inputs and cross-circuit check
   // ****************************************************************
   // Bit i of the combined vector: dedicated inputs 0..7, then lines 8..11.
   // Configurable lines count as inputs only in input direction.
   wire [NIN-1:0] all_in = {configurable_safe_lines_in & {NUM_CONFIG{~lines_out}},
                            dedicated_safe_inputs};
   // Line index parity decides the clock, so same-clock shorts stay silent.
   wire check_a = sample_pt & (phase == siot_pkg::SIOT_PH_A_LOW);
   wire check_b = sample_pt & (phase == siot_pkg::SIOT_PH_B_LOW);
   logic [NIN-1:0] mismatch;

   always_comb begin
      mismatch = '0;
      for (int i = 0; i < NIN; i++) begin
         if ((i % 2) == 0) begin
            mismatch[i] = check_a & all_in[i];
         end else begin
            mismatch[i] = check_b & all_in[i];
         end
      end
      mismatch = mismatch & xc_enable & {NIN{clock_mode}};
      mismatch[NIN-1:NUM_DEDICATED] = mismatch[NIN-1:NUM_DEDICATED] & {NUM_CONFIG{~lines_out}};
   end

   wire xc_clr = wr & hit_status & pwdata[1];
   wire in_chg = in_state != in_prev;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         xc_err <= '0;
         cfg_err <= 1'b0;
         in_state <= '0;
         in_prev <= '0;
      end else begin
         cfg_err <= next_cfg_err;
         xc_err <= mismatch | (xc_clr ? '0 : xc_err);
         in_state <= all_in;
         in_prev <= in_state;
      end
   end

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   wire [2:0] irq_ev = {in_chg, |mismatch, next_cfg_err & ~cfg_err};
   wire [2:0] irq_clr = (wr & hit_istat) ? pwdata[2:0] : 3'h0;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= 3'h0;
      end else begin
         irq_stat <= irq_ev | (irq_stat & ~irq_clr);
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_cfg_err;
      @(posedge sys_clk) disable iff (!rst_n)
         (clock_mode & lines_out) |=> cfg_err;
   endproperty
   a_cfg_err: assert property (p_cfg_err) else $error("config error missing");

   property p_no_drive_bad;
      @(posedge sys_clk) disable iff (!rst_n)
         next_cfg_err |=> (configurable_safe_lines_oe == '0);
   endproperty
   a_no_drive_bad: assert property (p_no_drive_bad) else $error("lines driven in bad config");

   property p_oe_group;
      @(posedge sys_clk) disable iff (!rst_n)
         (configurable_safe_lines_oe == '0) || (&configurable_safe_lines_oe);
   endproperty
   a_oe_group: assert property (p_oe_group) else $error("mixed line direction");

   property p_phase;
      @(posedge sys_clk) disable iff (!rst_n)
         clock_mode && $past(clock_mode) |-> !(!test_clock_a_out && !test_clock_b_out);
   endproperty
   a_phase: assert property (p_phase) else $error("clocks low together");

   property p_sig_mode;
      @(posedge sys_clk) disable iff (!rst_n)
         !clock_mode |=> test_clock_a_out == $past(ctrl[siot_pkg::CTRL_SIG_A_BIT]);
   endproperty
   a_sig_mode: assert property (p_sig_mode) else $error("signal output wrong");

   property p_pulse;
      @(posedge sys_clk) disable iff (!rst_n)
         pulse_gap |=> (configurable_safe_lines_out == '0);
   endproperty
   a_pulse: assert property (p_pulse) else $error("test pulse missing");

   property p_follow;
      @(posedge sys_clk) disable iff (!rst_n)
         (lines_out & ~clock_mode & ~pulse_gap) |=>
            configurable_safe_lines_out == $past(master_out_states);
   endproperty
   a_follow: assert property (p_follow) else $error("output not from master");

   property p_xc;
      @(posedge sys_clk) disable iff (!rst_n)
         (check_a & clock_mode & xc_enable[0] & dedicated_safe_inputs[0]) |=> xc_err[0];
   endproperty
   a_xc: assert property (p_xc) else $error("cross-circuit missed");

   property p_no_xc_same;
      @(posedge sys_clk) disable iff (!rst_n)
         (check_b && !xc_clr) |=> $stable(xc_err[0]);
   endproperty
   a_no_xc_same: assert property (p_no_xc_same) else $error("even input checked on B");

   sequence s_b_falls;
      ##100 $fell(test_clock_b_out);
   endsequence
   property p_phase_order;
      @(posedge sys_clk) disable iff (!rst_n || !clock_mode)
         $past(clock_mode) && $past(clock_mode, 2) && $fell(test_clock_a_out) |-> s_b_falls;
   endproperty
   a_phase_order: assert property (p_phase_order) else $error("clock B phase wrong");
endmodule : siot_unit

`default_nettype wire

/* dv/siot_field.sv */
// Field wiring model: sensors fed from the unit's test clocks.
`timescale 1ns/1ns
`default_nettype none

module siot_field (
   // Test clocks from the unit.
   input wire logic clk_a,
   input wire logic clk_b,
   // Configurable line drivers of the unit.
   input wire logic [3:0] lines_out,
   input wire logic [3:0] lines_oe,
   // Faults: short to supply, or fed from the other clock.
   input wire logic [11:0] stuck_hi,
   input wire logic [11:0] swap,
   // Levels seen at the unit's input pins.
   output logic [7:0] ded_in,
   output logic [3:0] lines_in
);
   logic [11:0] lvl;

   always_comb begin
      for (int i = 0; i < 12; i++) begin
         lvl[i] = (((i % 2) == 0) ^ swap[i]) ? clk_a : clk_b;
         if (stuck_hi[i]) begin
            lvl[i] = 1'b1;
         end
      end
   end

   assign ded_in = lvl[7:0];
   // A driven line shows its own driver; a released one its sensor.
   assign lines_in = (lines_oe & lines_out) | (~lines_oe & lvl[11:8]);
endmodule : siot_field

`default_nettype wire

/* dv/siot_unit_tb_top.sv */
// Self-checking testbench of the safe I/O unit.
`timescale 1ns/1ns
`default_nettype none

module siot_unit_tb_top;
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, tca, tcb, irq;
   logic [7:0] paddr, ded;
   logic [31:0] pwdata, prdata;
   logic [3:0] lin, lout, loe, master;
   logic [11:0] stuck_hi, swap;
   logic [32:0] exp_q[$];
   int num_errors = 0;
   int checks = 0;

   siot_unit uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dedicated_safe_inputs(ded), .configurable_safe_lines_in(lin),
      .configurable_safe_lines_out(lout), .configurable_safe_lines_oe(loe),
      .test_clock_a_out(tca), .test_clock_b_out(tcb), .master_out_states(master),
      .irq(irq));

   siot_field field (.clk_a(tca), .clk_b(tcb), .lines_out(lout), .lines_oe(loe),
      .stuck_hi(stuck_hi), .swap(swap), .ded_in(ded), .lines_in(lin));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic chk(input string n, input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", n, exp, seen);
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      // No wait-state count is assumed; the watchdog ends a hung access.
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [32:0] exp);
      exp_q.push_back(exp);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : wt

   // Read data is compared at the edge that ends the access.
   always @(posedge sys_clk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         chk("prdata", {pslverr, prdata}, exp_q.pop_front());
      end
   end

   initial begin
      repeat (50000) @(posedge sys_clk);
      num_errors++;
      give_verdict();
   end

   initial begin
      int na, nb, nab;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      master = 4'h0;
      stuck_hi = 12'h000;
      swap = 12'h000;
      void'($urandom(78));
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      wt(1);
      chk("oe", loe, 4'h0);
      rd(siot_pkg::ADDR_CTRL, 33'h0);
      rd(siot_pkg::ADDR_XC_ENABLE, 33'h0);
      rd(8'h1C, 33'h1_0000_0000);
      // Signal mode with lines driven: every signal level pair.
      for (int k = 0; k < 4; k++) begin
         @(posedge sys_clk);
         master <= 4'($urandom()) | 4'h1;
         apb(1'b1, siot_pkg::ADDR_CTRL, 32'(k * 4 + 1));
         wt(5);
         chk("tc_a", tca, k[0]);
         chk("tc_b", tcb, k[1]);
         chk("oe", loe, 4'hF);
         rd(siot_pkg::ADDR_OUT_DATA, {29'h0, master});
         rd(siot_pkg::ADDR_INPUTS, {25'h0, {4{k[1], k[0]}}});
         na = 0;
         nb = 0;
         for (int c = 0; c < 2000; c++) begin
            @(negedge sys_clk);
            if (lout === 4'h0) na++;
            else if (lout === master) nb++;
         end
         chk("pulse", na, 20);
         chk("follow", nb, 1980);
      end
      // Clock mode together with driven lines is refused.
      apb(1'b1, siot_pkg::ADDR_IRQ_MASK, 32'h1);
      apb(1'b1, siot_pkg::ADDR_CTRL, 32'h3);
      rd(siot_pkg::ADDR_STATUS, 33'h1);
      wt(2);
      chk("oe", loe, 4'h0);
      chk("irq", irq, 1'b1);
      apb(1'b1, siot_pkg::ADDR_IRQ_STAT, 32'h1);
      wt(2);
      chk("irq", irq, 1'b0);
      // Clock mode, lines as inputs, all inputs checked.
      apb(1'b1, siot_pkg::ADDR_CTRL, 32'h2);
      apb(1'b1, siot_pkg::ADDR_XC_ENABLE, 32'hFFF);
      apb(1'b1, siot_pkg::ADDR_IRQ_MASK, 32'h2);
      apb(1'b1, siot_pkg::ADDR_IRQ_STAT, 32'h7);
      wt(400);
      rd(siot_pkg::ADDR_STATUS, 33'h0);
      rd(siot_pkg::ADDR_IRQ_STAT, 33'h4);
      wt(2);
      chk("irq", irq, 1'b0);
      na = 0;
      nb = 0;
      nab = 0;
      for (int c = 0; c < 400; c++) begin
         @(negedge sys_clk);
         na += int'(!tca);
         nb += int'(!tcb);
         nab += int'(!tca && !tcb);
      end
      chk("a_low", na, 100);
      chk("b_low", nb, 100);
      chk("both_low", nab, 0);
      stuck_hi <= 12'h001;
      wt(400);
      rd(siot_pkg::ADDR_STATUS, 33'h0001_0000);
      wt(2);
      chk("irq", irq, 1'b1);
      @(posedge sys_clk);
      stuck_hi <= 12'h000;
      apb(1'b1, siot_pkg::ADDR_STATUS, 32'h2);
      rd(siot_pkg::ADDR_STATUS, 33'h0);
      @(posedge sys_clk);
      swap <= 12'h200;
      wt(400);
      rd(siot_pkg::ADDR_STATUS, 33'h0200_0000);
      wt(4);
      give_verdict();
   end
endmodule : siot_unit_tb_top

`default_nettype wire
